// [core/tsm_counter.sv]
`timescale 1ns/1ns
`default_nettype none
module tsm_counter (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clr,
    input wire logic inc,
    input wire logic cmp_ne,
    input wire logic [tsm_pkg::CW-1:0] cmp_val,
    output logic [tsm_pkg::CW-1:0] count,
    output logic match
);
    import tsm_pkg::*;

    // Event counter, clear wins over step
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (clr) begin
            count <= '0;
        end else if (inc) begin
            count <= count + 16'h0001;
        end
    end

    // Single comparator, equal or not equal only
    assign match = cmp_ne ? (count != cmp_val) : (count == cmp_val);
endmodule
`default_nettype wire

// [core/tsm_pkg.sv]
package tsm_pkg;
    // Sizes of the sequencer
    localparam int NSTATE = 16;
    localparam int SW = 4;
    localparam int CW = 16;
    localparam int NCNT = 4;
    localparam int NFLAG = 4;
    localparam int NPCMP = 4;
    localparam int PW = 16;
    localparam int PWORDS = 64;
    // Register byte offsets
    localparam logic [8:0] A_CTRL = 9'h000;
    localparam logic [8:0] A_STATUS = 9'h004;
    localparam logic [8:0] A_IRQ_STAT = 9'h008;
    localparam logic [8:0] A_IRQ_CLR = 9'h00c;
    localparam logic [8:0] A_IRQ_EN = 9'h010;
    localparam logic [8:0] A_CCMP = 9'h020;
    localparam logic [8:0] A_PCMP = 9'h030;
    localparam logic [8:0] A_CVAL = 9'h040;
    localparam logic [8:0] A_PROG = 9'h100;
    // Field positions
    localparam int CTRL_START = 0;
    localparam int CTRL_STOP = 1;
    localparam int ST_RUN = 4;
    localparam int ST_DONE = 5;
    localparam int ST_FLAG = 8;
    localparam int CCMP_NE = 16;
    localparam int PCMP_OP = 16;
    localparam int COND2_POS = 16;
    localparam int PATHS_POS = 30;
    localparam int NIRQ = 3;
    // Reset values
    localparam logic [31:0] WORD_RST = 32'h0000_0000;
    localparam logic [NIRQ-1:0] IRQ_EN_RST = 3'h0;
    // Probe compare operators
    typedef enum logic [2:0] {OP_EQ, OP_NE, OP_GT, OP_LT, OP_GE, OP_LE} tsm_op_t;
    // Sequencer run states
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_RUN, SEQ_DONE} tsm_seq_t;
    // One action block, one program word
    typedef struct packed {
        logic trig;
        logic [NCNT-1:0] cnt_inc;
        logic [NCNT-1:0] cnt_rst;
        logic [NFLAG-1:0] flg_clr;
        logic [NFLAG-1:0] flg_set;
        logic [SW-1:0] target;
    } tsm_act_t;
    // One branch condition, half a condition word
    typedef struct packed {
        logic join_and;
        logic cnt_en;
        logic [1:0] cnt_sel;
        logic prb_and;
        logic [NPCMP-1:0] prb_mask;
    } tsm_cond_t;
endpackage

// [core/tsm_probe_cmp.sv]
`timescale 1ns/1ns
`default_nettype none
module tsm_probe_cmp (
    input wire logic [tsm_pkg::PW-1:0] probe,
    input wire logic [2:0] op,
    input wire logic [tsm_pkg::PW-1:0] value,
    output logic match
);
    import tsm_pkg::*;

    // Magnitude compare of probe against constant
    always_comb begin
        unique case (tsm_op_t'(op))
            OP_EQ: match = (probe == value);
            OP_NE: match = (probe != value);
            OP_GT: match = (probe > value);
            OP_LT: match = (probe < value);
            OP_GE: match = (probe >= value);
            OP_LE: match = (probe <= value);
            // Unused operator codes never match
            default: match = 1'b0;
        endcase
    end
endmodule
`default_nettype wire

// [core/tsm_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tsm_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [tsm_pkg::PW-1:0] probe,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic trigger_out,
    output logic [tsm_pkg::NFLAG-1:0] status_flag,
    output logic irq
);
    import tsm_pkg::*;

    // Bus data-phase state
    logic dp_wr;
    logic dp_rd;
    logic [8:0] dp_addr;
    // Program store, four words per state
    logic [31:0] prog [PWORDS];
    // Comparator setup
    logic [16:0] ccfg [NCNT];
    logic [18:0] pcfg [NPCMP];
    // Interrupt registers
    logic [NIRQ-1:0] irq_stat;
    logic [NIRQ-1:0] irq_en;
    // Sequencer state
    tsm_seq_t seq_q;
    tsm_seq_t next_seq;
    logic [SW-1:0] state_idx;
    logic [SW-1:0] next_state_idx;
    logic [NFLAG-1:0] next_flags;
    logic [NIRQ-1:0] next_irq_stat;
    // Counter and comparator results
    logic [CW-1:0] cnt [NCNT];
    logic [NCNT-1:0] cmatch;
    logic [NPCMP-1:0] pmatch;

    // Address phase accepted
    wire take = hsel & htrans[1] & hready;

    // Write decodes
    wire wr_ctrl = dp_wr & (dp_addr == A_CTRL);
    wire wr_irq_clr = dp_wr & (dp_addr == A_IRQ_CLR);
    wire wr_irq_en = dp_wr & (dp_addr == A_IRQ_EN);
    wire wr_ccmp = dp_wr & (dp_addr[8:4] == A_CCMP[8:4]);
    wire wr_pcmp = dp_wr & (dp_addr[8:4] == A_PCMP[8:4]);
    wire wr_prog = dp_wr & (dp_addr[8] == A_PROG[8]);
    wire [1:0] reg_sel = dp_addr[3:2];
    wire [5:0] prog_sel = dp_addr[7:2];

    // Host commands, start wins over stop
    wire start = wr_ctrl & hwdata[CTRL_START];
    wire stop = wr_ctrl & hwdata[CTRL_STOP] & ~start;

    // Sequencer advances once per cycle while running
    wire adv = (seq_q == SEQ_RUN);

    // Current state's condition word and path count
    wire [31:0] cond_word = prog[{state_idx, 2'b11}];
    wire [1:0] paths = cond_word[PATHS_POS+1:PATHS_POS];
    wire tsm_cond_t cond1 = cond_word[COND2_POS-8:0];
    wire tsm_cond_t cond2 = cond_word[COND2_POS+8:COND2_POS];

    // Evaluate one branch condition
    function automatic logic cond_eval(
        input tsm_cond_t c,
        input logic [NPCMP-1:0] pm,
        input logic [NCNT-1:0] cm
    );
        logic p_use;
        logic p_val;
        logic c_val;
        p_use = |c.prb_mask;
        p_val = c.prb_and ? &(pm | ~c.prb_mask) : |(pm & c.prb_mask);
        c_val = cm[c.cnt_sel];
        if (p_use && c.cnt_en) begin
            return c.join_and ? (p_val && c_val) : (p_val || c_val);
        end else if (p_use) begin
            return p_val;
        end else if (c.cnt_en) begin
            return c_val;
        end
        return 1'b1;
    endfunction

    // Branch condition results
    wire c1 = cond_eval(cond1, pmatch, cmatch);
    wire c2 = cond_eval(cond2, pmatch, cmatch);

    // Block choice by path count
    wire [1:0] sel_two = c1 ? 2'd0 : 2'd1;
    wire [1:0] sel_three = c1 ? 2'd0 : (c2 ? 2'd1 : 2'd2);
    wire [1:0] blk_sel = (paths == 2'd3) ? sel_three :
                         (paths == 2'd2) ? sel_two : 2'd0;

    // Chosen action block
    wire tsm_act_t act = prog[{state_idx, blk_sel}][20:0];
    wire [SW-1:0] nxt_target = act.target;

    // Raw event sources for interrupts
    wire ev_trig = adv & act.trig;
    wire ev_flag = adv & |(act.flg_set & ~status_flag);
    wire [NIRQ-1:0] irq_ev = {start, ev_flag, ev_trig};

    // Run state transitions
    always_comb begin
        next_seq = seq_q;
        unique case (seq_q)
            SEQ_IDLE: begin
                if (start) next_seq = SEQ_RUN;
            end
            SEQ_RUN: begin
                if (start) next_seq = SEQ_RUN;
                else if (stop) next_seq = SEQ_IDLE;
                else if (act.trig) next_seq = SEQ_DONE;
            end
            SEQ_DONE: begin
                if (start) next_seq = SEQ_RUN;
                else if (stop) next_seq = SEQ_IDLE;
            end
        endcase
    end

    // Next state index
    assign next_state_idx = start ? '0 :
                            (adv & ~act.trig) ? nxt_target : state_idx;

    // Next flags, set wins over clear in one block
    assign next_flags = start ? '0 :
                        adv ? ((status_flag & ~act.flg_clr) | act.flg_set) :
                        status_flag;

    // Sticky status, event wins over clear
    assign next_irq_stat = (irq_stat & ~(hwdata[NIRQ-1:0] & {NIRQ{wr_irq_clr}})) | irq_ev;

    // Read data mux
    wire [31:0] status_word = {20'h0, status_flag, 2'b00,
                               (seq_q == SEQ_DONE), adv, state_idx};
    wire [31:0] rd_data =
        (dp_addr == A_STATUS) ? status_word :
        (dp_addr == A_IRQ_STAT) ? {29'h0, irq_stat} :
        (dp_addr == A_IRQ_EN) ? {29'h0, irq_en} :
        (dp_addr[8:4] == A_CCMP[8:4]) ? {15'h0, ccfg[reg_sel]} :
        (dp_addr[8:4] == A_PCMP[8:4]) ? {13'h0, pcfg[reg_sel]} :
        (dp_addr[8:4] == A_CVAL[8:4]) ? {16'h0, cnt[reg_sel]} :
        (dp_addr[8] == A_PROG[8]) ? prog[prog_sel] :
        WORD_RST;

    // Bus phase tracking, reads insert one wait
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_wr <= 1'b0;
            dp_rd <= 1'b0;
            dp_addr <= '0;
            hreadyout <= 1'b1;
        end else begin
            dp_wr <= take & hwrite;
            dp_rd <= take & ~hwrite;
            hreadyout <= ~(take & ~hwrite);
            if (take) dp_addr <= haddr[8:0];
        end
    end

    // Read data and response
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= WORD_RST;
            hresp <= 1'b0;
        end else if (dp_rd) begin
            hrdata <= rd_data;
        end
    end

    // Program store writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < PWORDS; i++) prog[i] <= WORD_RST;
        end else if (wr_prog) begin
            prog[prog_sel] <= hwdata;
        end
    end

    // Comparator setup writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NCNT; i++) ccfg[i] <= '0;
            for (int i = 0; i < NPCMP; i++) pcfg[i] <= '0;
        end else begin
            if (wr_ccmp) ccfg[reg_sel] <= hwdata[16:0];
            if (wr_pcmp) pcfg[reg_sel] <= hwdata[18:0];
        end
    end

    // Interrupt status, enable and line
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat <= '0;
            irq_en <= IRQ_EN_RST;
            irq <= 1'b0;
        end else begin
            irq_stat <= next_irq_stat;
            if (wr_irq_en) irq_en <= hwdata[NIRQ-1:0];
            irq <= |(next_irq_stat & (wr_irq_en ? hwdata[NIRQ-1:0] : irq_en));
        end
    end

    // Sequencer registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seq_q <= SEQ_IDLE;
            state_idx <= '0;
            status_flag <= '0;
            trigger_out <= 1'b0;
        end else begin
            seq_q <= next_seq;
            state_idx <= next_state_idx;
            status_flag <= next_flags;
            trigger_out <= ev_trig;
        end
    end

    // Four event counters with their comparators
    for (genvar g = 0; g < NCNT; g++) begin : g_cnt
        tsm_counter u_cnt (
            .clk(hclk),
            .rst_n(hresetn),
            .clr(start | (adv & act.cnt_rst[g])),
            .inc(adv & act.cnt_inc[g]),
            .cmp_ne(ccfg[g][CCMP_NE]),
            .cmp_val(ccfg[g][CW-1:0]),
            .count(cnt[g]),
            .match(cmatch[g])
        );
    end

    // Probe comparators on the single probe port
    for (genvar g = 0; g < NPCMP; g++) begin : g_pcmp
        tsm_probe_cmp u_pcmp (
            .probe(probe),
            .op(pcfg[g][PCMP_OP+2:PCMP_OP]),
            .value(pcfg[g][PW-1:0]),
            .match(pmatch[g])
        );
    end

    // Assertion helpers: each block's word and where it leads
    wire tsm_act_t blk0 = prog[{state_idx, 2'd0}][20:0];
    wire tsm_act_t blk1 = prog[{state_idx, 2'd1}][20:0];
    wire tsm_act_t blk2 = prog[{state_idx, 2'd2}][20:0];
    // A trigger block holds the state, any other block jumps
    wire [SW-1:0] dest0 = blk0.trig ? state_idx : blk0.target;
    wire [SW-1:0] dest1 = blk1.trig ? state_idx : blk1.target;
    wire [SW-1:0] dest2 = blk2.trig ? state_idx : blk2.target;

    // Checks on sequencer behaviour
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    AST_START_CLEAR: assert property (
        start |=> (state_idx == 4'h0) && (status_flag == 4'h0) && (cnt[0] == 16'h0)
    ) else $error("start did not clear state, flags or counter");

    AST_JUMP: assert property (
        adv && !act.trig && !start && !stop |=> state_idx == $past(nxt_target)
    ) else $error("jump did not reach target");

    AST_ONE_PATH: assert property (
        adv && !start && (paths < 2'd2)
        |=> (state_idx == $past(dest0)) && (trigger_out == $past(blk0.trig))
    ) else $error("one-path state chose another block");

    AST_TWO_FIRST: assert property (
        adv && !start && (paths == 2'd2) && c1
        |=> (state_idx == $past(dest0)) && (trigger_out == $past(blk0.trig))
    ) else $error("two-path true branch wrong");

    AST_TWO_PATH: assert property (
        adv && !start && (paths == 2'd2) && !c1
        |=> (state_idx == $past(dest1)) && (trigger_out == $past(blk1.trig))
    ) else $error("two-path selection wrong");

    AST_THREE_FIRST: assert property (
        adv && !start && (paths == 2'd3) && c1
        |=> (state_idx == $past(dest0)) && (trigger_out == $past(blk0.trig))
    ) else $error("three-path first branch wrong");

    AST_THREE_SECOND: assert property (
        adv && !start && (paths == 2'd3) && !c1 && c2
        |=> (state_idx == $past(dest1)) && (trigger_out == $past(blk1.trig))
    ) else $error("three-path second branch wrong");

    AST_THREE_PATH: assert property (
        adv && !start && (paths == 2'd3) && !c1 && !c2
        |=> (state_idx == $past(dest2)) && (trigger_out == $past(blk2.trig))
    ) else $error("three-path selection wrong");

    AST_CNT_CLEAR: assert property (
        adv && act.cnt_rst[0] |=> cnt[0] == 16'h0
    ) else $error("counter clear failed");

    AST_CNT_STEP: assert property (
        adv && act.cnt_inc[1] && !act.cnt_rst[1] && !start
        |=> cnt[1] == 16'($past(cnt[1]) + 16'h1)
    ) else $error("counter step failed");

    AST_TRIG_PULSE: assert property (
        adv && act.trig && !start && !stop |=> trigger_out && (seq_q == SEQ_DONE) ##1 !trigger_out
    ) else $error("trigger pulse wrong");

    AST_FLAG_SET: assert property (
        adv && act.flg_set[2] && !start |=> status_flag[2]
    ) else $error("flag set not seen");

    AST_FLAG_HOLD: assert property (
        !adv && !start |=> status_flag == $past(status_flag)
    ) else $error("flags changed while stopped");

    AST_FLAG_CLEAR: assert property (
        adv && act.flg_clr[0] && !act.flg_set[0] && !start |=> !status_flag[0]
    ) else $error("flag clear not seen");

    AST_TRIG_HALT: assert property (
        (seq_q == SEQ_DONE) && !start |=> state_idx == $past(state_idx)
    ) else $error("halted sequencer moved");
endmodule
`default_nettype wire

// [verif/tsm_probe_src.sv]
`timescale 1ns/1ns
`default_nettype none
// Stand-in for the probed user logic, driving a held pattern
module tsm_probe_src (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [tsm_pkg::PW-1:0] pattern,
    output logic [tsm_pkg::PW-1:0] probe
);
    import tsm_pkg::*;
    // Registered so the probe only moves just after a clock edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            probe <= '0;
        end else begin
            probe <= pattern;
        end
    end
endmodule
`default_nettype wire

// [verif/tsm_top_tb.sv]
`timescale 1ns/1ns
`default_nettype none
// Host-side bench: loads programs over the bus and checks the outcome
module tsm_top_tb;
    import tsm_pkg::*;
    logic hclk, hresetn, hsel, hwrite;
    logic [31:0] haddr, hwdata, hrdata, st;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [PW-1:0] pattern, probe;
    logic hreadyout, hresp, trigger_out, irq;
    logic [NFLAG-1:0] status_flag;
    int err_count = 0;
    int checks = 0;
    int trig_n = 0;
    // Design under test, bus ready looped back
    tsm_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .probe(probe),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .trigger_out(trigger_out),
        .status_flag(status_flag), .irq(irq));
    // Probed logic model
    tsm_probe_src u_src (.hclk(hclk), .hresetn(hresetn), .pattern(pattern), .probe(probe));
    // Clock, 100 ns period
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    // Counts trigger pulses, one per edge seen high
    always @(posedge hclk) begin
        if (trigger_out === 1'b1) begin
            trig_n <= trig_n + 1;
        end
    end
    // Compare and tally
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic print_verdict;
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Single word write, entered just after an edge
    task automatic ahb_wr(input logic [8:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= 1'b1;
        haddr <= {23'h000000, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask
    // Single word read, data taken at the completing edge
    task automatic ahb_rd(input logic [8:0] a, output logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= 1'b0;
        haddr <= {23'h000000, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask
    // Program word write
    task automatic pw(input int w, input logic [31:0] d);
        ahb_wr(A_PROG + 9'(4 * w), d);
    endtask
    // Start the program and poll until it reports done
    task automatic run_prog(input int exp_trig);
        int n;
        n = 0;
        ahb_wr(A_CTRL, 32'h0000_0001);
        st = 32'h0000_0000;
        while (st[ST_DONE] !== 1'b1 && n < 64) begin
            ahb_rd(A_STATUS, st);
            n++;
        end
        chk(32'(trig_n), 32'(exp_trig));
        chk({31'h0, trigger_out}, 32'h0000_0000);
    endtask
    // Watchdog against a hung bus or sequencer
    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        print_verdict;
    end
    // Main sequence
    initial begin
        hsel = 1'b0;
        haddr = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        pattern = 16'h0000;
        hresetn = 1'b0;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Idle after reset, unmapped and write-only places read zero
        ahb_rd(A_STATUS, st);
        chk(st, 32'h0000_0000);
        chk({31'h0, hresp}, 32'h0000_0000);
        ahb_rd(9'h0fc, st);
        chk(st, 32'h0000_0000);
        ahb_rd(A_CTRL, st);
        chk(st, 32'h0000_0000);
        ahb_rd(A_IRQ_EN, st);
        chk(st, 32'h0000_0000);
        // One-way chain: 0 -> 1 -> 2 with counting, flag set, then trigger
        ahb_wr(A_IRQ_EN, 32'h0000_0001);
        pw(0, 32'h0003_0011);
        pw(4, 32'h0001_0002);
        pw(8, 32'h0010_0000);
        run_prog(1);
        chk(st, 32'h0000_0122);
        chk({28'h0, status_flag}, 32'h0000_0001);
        ahb_rd(A_CVAL, st);
        chk(st, 32'h0000_0002);
        ahb_rd(A_CVAL + 9'h004, st);
        chk(st, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0001);
        ahb_wr(A_IRQ_CLR, 32'h0000_0001);
        // Line drops at the edge that ends the write, look one edge later
        @(posedge hclk);
        chk({31'h0, irq}, 32'h0000_0000);
        ahb_rd(A_IRQ_STAT, st);
        chk(st, 32'h0000_0006);
        ahb_wr(A_IRQ_EN, 32'h0000_0000);
        // Two-way on a counter compare: loop until count equals 3
        ahb_wr(A_CCMP, 32'h0000_0003);
        pw(0, 32'h0010_1100);
        pw(1, 32'h0001_0010);
        pw(3, 32'h8000_0180);
        run_prog(2);
        chk(st, 32'h0000_0020);
        ahb_rd(A_CVAL, st);
        chk(st, 32'h0000_0000);
        chk({28'h0, status_flag}, 32'h0000_0000);
        chk({31'h0, irq}, 32'h0000_0000);
        // Three-way on probe compares, first condition has priority
        ahb_wr(A_PCMP, 32'h0000_00aa);
        ahb_wr(A_PCMP + 9'h004, 32'h0004_0000);
        pw(0, 32'h0000_0021);
        pw(1, 32'h0000_0042);
        pw(2, 32'h0000_0000);
        pw(3, 32'hc102_0101);
        pw(4, 32'h0010_0000);
        pw(8, 32'h0010_0000);
        pattern <= 16'h00aa;
        repeat (3) @(posedge hclk);
        run_prog(3);
        chk(st, 32'h0000_0221);
        pattern <= 16'h0001;
        repeat (3) @(posedge hclk);
        run_prog(4);
        chk(st, 32'h0000_0422);
        chk({28'h0, status_flag}, 32'h0000_0004);
        // Neither condition holds: default block triggers in state 0
        ahb_wr(A_PCMP + 9'h004, 32'h0006_0000);
        pw(2, 32'h0010_0080);
        run_prog(5);
        chk(st, 32'h0000_0820);
        // Stop leaves the halted state, flags stay
        ahb_wr(A_CTRL, 32'h0000_0002);
        ahb_rd(A_STATUS, st);
        chk(st, 32'h0000_0800);
        print_verdict;
    end
endmodule
`default_nettype wire
